// ==== core/iecg_top.sv ====
// Purpose: idle-entry sequencer that stops per-module clocks after an idle instruction
// Assumes: busy and stopped indications are on i_clk; serial port reset bits are synchronous
// Notes:   wake-up sequencing and auto-wakeup beyond re-gating are left to neighbours
`timescale 1ns/1ps

module iecg_top
    import iecg_pkg::*;
(
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    // cpu side
    input  wire logic               i_idle_instr,
    input  wire logic [DOM_W-1:0]   i_idle_control_reg,
    input  wire logic [1:0]         i_master_idle_ctrl,   // bit0 dma, bit1 host port
    input  wire logic [NMOD-1:0]    i_peripheral_idle_control_reg,
    input  wire logic               i_cpu_pipe_stopped,
    // module activity
    input  wire iecg_act_t          i_act,
    input  wire iecg_ser_t [NSER-1:0] i_ser,
    // status and gating
    output logic [DOM_W-1:0]        o_idle_status_reg,
    output logic [NMOD-1:0]         o_idle_req,
    output logic [NMOD-1:0]         o_clk_gated
);
    logic [DOM_W-1:0] stat_q;
    logic [DOM_W-1:0] stat_d;
    logic [NMOD-1:0]  want;
    logic [NMOD-1:0]  ack;
    logic [NMOD-1:0]  req;
    logic [NMOD-1:0]  gated;
    logic             cpu_stopped;
    logic             dma_wake;
    logic             peri_on;

    always_comb
    begin
        stat_d = stat_q;
        if (i_idle_instr)
        begin
            stat_d = i_idle_control_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            stat_q <= IDLE_STAT_RST;
        end
        else
        begin
            stat_q <= stat_d;
        end
    end

    // serial port gate decision, used by the ack terms only
    function automatic logic ser_ok(input iecg_ser_t s);
        if (s.ext_clk)
        begin
            ser_ok = !s.busy;
        end
        else
        begin
            ser_ok = !s.serial_tx_reset_n && !s.serial_rx_reset_n;
        end
    endfunction : ser_ok

    assign cpu_stopped = gated[M_CPU];
    assign peri_on     = stat_q[DOM_PERI];
    // any serial data request pulls the dma engine out of idle for one service window
    assign dma_wake    = i_ser[0].dma_req | i_ser[1].dma_req | i_ser[2].dma_req;

    always_comb
    begin
        want = '0;
        ack  = '0;
        want[M_CPU]   = stat_q[DOM_CPU];
        ack[M_CPU]    = i_cpu_pipe_stopped;
        want[M_SYSC]  = stat_q[DOM_CPU];
        ack[M_SYSC]   = cpu_stopped;
        want[M_DMA]   = stat_q[DOM_MP] & i_master_idle_ctrl[0] & !dma_wake;
        ack[M_DMA]    = !i_act.dma_busy;
        want[M_HPI]   = stat_q[DOM_MP] & i_master_idle_ctrl[1];
        ack[M_HPI]    = 1'b1;
        want[M_ICACH] = stat_q[DOM_IC];
        ack[M_ICACH]  = !i_act.instruction_cache_line_busy & !i_act.instruction_cache_fetch_busy;
        for (int m = M_TMR; m <= M_PGPIO; m++)
        begin
            want[m] = peri_on & i_peripheral_idle_control_reg[m];
            ack[m]  = 1'b1;
        end
        for (int k = 0; k < NSER; k++)
        begin
            // on an externally clocked port the dma request also un-gates the port so it can feed the transfer
            want[M_SER0+k] = peri_on & i_peripheral_idle_control_reg[M_SER0+k]
                             & !(i_ser[k].ext_clk & i_ser[k].dma_req);
            ack[M_SER0+k]  = ser_ok(i_ser[k]);
        end
        want[M_I2C]  = peri_on & i_peripheral_idle_control_reg[M_I2C];
        ack[M_I2C]   = !i_act.i2c_busy;
        want[M_UART] = peri_on & i_peripheral_idle_control_reg[M_UART];
        ack[M_UART]  = !i_act.uart_busy;
    end

    genvar g;
    generate
        for (g = 0; g < NMOD; g++)
        begin : g_cell
            iecg_gate_cell u_cell (
                .i_clk   (i_clk),
                .i_rstn  (i_rstn),
                .i_want  (want[g]),
                .i_ack   (ack[g]),
                .o_req   (req[g]),
                .o_gated (gated[g])
            );
        end
    endgenerate

    assign o_idle_status_reg = stat_q;
    assign o_idle_req        = req;
    assign o_clk_gated       = gated;

    // the module map and the gating vectors must agree, or a module would lose its bit
    if (NMOD != M_UART + 1 || NSER != M_SER2 - M_SER0 + 1)
    begin : g_map_check
        $error("module map does not fit the gating vectors");
    end

    a_status_copy: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_idle_instr |=> stat_q == $past(i_idle_control_reg))
        else $error("idle status not copied from control");
    a_cpu_after_pipe: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(gated[M_CPU]) |-> $past(i_cpu_pipe_stopped))
        else $error("cpu gated before pipeline stopped");
    a_sysc_after_cpu: assert property (@(posedge i_clk) disable iff (!i_rstn)
        gated[M_SYSC] |-> $past(gated[M_CPU]))
        else $error("system control gated before cpu stopped");
    a_dma_no_busy: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(gated[M_DMA]) |-> !$past(i_act.dma_busy))
        else $error("dma gated during transfer");
    a_dma_wake: assert property (@(posedge i_clk) disable iff (!i_rstn)
        dma_wake |-> ##2 !gated[M_DMA])
        else $error("dma not woken by serial request");
    a_hpi_immed: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (stat_q[DOM_MP] && i_master_idle_ctrl[1]) [*2] |=> gated[M_HPI])
        else $error("host port not gated promptly");
    a_instruction_cache_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(gated[M_ICACH]) |-> !$past(i_act.instruction_cache_line_busy)
                                  && !$past(i_act.instruction_cache_fetch_busy))
        else $error("instruction_cache gated during transfer");
    a_timer_immed: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (peri_on && i_peripheral_idle_control_reg[M_WDOG]) [*2] |=> gated[M_WDOG])
        else $error("watchdog not gated promptly");
    a_ser_int_reset: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(gated[M_SER1]) && !$past(i_ser[1].ext_clk)
        |-> !$past(i_ser[1].serial_tx_reset_n) && !$past(i_ser[1].serial_rx_reset_n))
        else $error("internal serial port gated out of reset");
    a_ser_ext_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(gated[M_SER0]) && $past(i_ser[0].ext_clk) |-> !$past(i_ser[0].busy))
        else $error("external serial port gated while busy");
    a_ser_dma_wake: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ser[0].ext_clk && i_ser[0].dma_req |-> ##2 !gated[M_SER0])
        else $error("serial port not woken for dma");
    a_i2c_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(gated[M_I2C]) |-> !$past(i_act.i2c_busy))
        else $error("i2c gated while busy");
    a_uart_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(gated[M_UART]) |-> !$past(i_act.uart_busy))
        else $error("uart gated while busy");
    a_peri_needs: assert property (@(posedge i_clk) disable iff (!i_rstn)
        gated[M_GPIO] |-> $past(peri_on) && $past(i_peripheral_idle_control_reg[M_GPIO]))
        else $error("peripheral gated without control and status");

    // per-module checks, repeated over the module map
    genvar a;
    generate
        for (a = 0; a < NMOD; a++)
        begin : g_chk_all
            a_gate_wanted: assert property (@(posedge i_clk) disable iff (!i_rstn)
                gated[a] |-> $past(want[a]) && $past(req[a]))
                else $error("clock gated without idle request");
        end
        for (a = M_TMR; a <= M_PGPIO; a++)
        begin : g_chk_immed
            a_immed_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
                (peri_on && i_peripheral_idle_control_reg[a]) [*2] |=> gated[a])
                else $error("immediate peripheral not gated promptly");
        end
        for (a = 0; a < NSER; a++)
        begin : g_chk_ser
            // an internally clocked port with tx or rx out of reset keeps its clock from the next cycle
            a_ser_int_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
                !i_ser[a].ext_clk
                && (i_ser[a].serial_tx_reset_n || i_ser[a].serial_rx_reset_n)
                |=> !gated[M_SER0+a])
                else $error("internal serial port gated while out of reset");
        end
    endgenerate

    c_cpu_idle:  cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(gated[M_SYSC]));
    c_dma_wait:  cover property (@(posedge i_clk) disable iff (!i_rstn)
        req[M_DMA] && i_act.dma_busy ##1 !i_act.dma_busy ##1 gated[M_DMA]);
    c_ser_wake:  cover property (@(posedge i_clk) disable iff (!i_rstn)
        gated[M_SER0] ##1 i_ser[0].dma_req);
    c_uart_gate: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(gated[M_UART]));

endmodule : iecg_top

// ==== core/iecg_pkg.sv ====
// Purpose: shared types and constants for the idle-entry clock gating sequencer
// Assumes: single core clock, asynchronous active-low reset
// Notes:   one bit per gated module in every module vector
package iecg_pkg;

    // idle control / status domain bits
    localparam int DOM_CPU  = 0;
    localparam int DOM_MP   = 1;
    localparam int DOM_IC   = 2;
    localparam int DOM_PERI = 3;
    localparam int DOM_W    = 4;

    localparam logic [DOM_W-1:0] IDLE_CTRL_RST = 4'h0;
    localparam logic [DOM_W-1:0] IDLE_STAT_RST = 4'h0;

    // gated module indices
    localparam int M_CPU   = 0;
    localparam int M_SYSC  = 1;   // intc, idle ctrl, pll ctrl, config registers
    localparam int M_DMA   = 2;
    localparam int M_HPI   = 3;
    localparam int M_ICACH = 4;
    localparam int M_TMR   = 5;   // general timers
    localparam int M_WDOG  = 6;
    localparam int M_OSTK  = 7;
    localparam int M_GPIO  = 8;
    localparam int M_PGPIO = 9;
    localparam int M_SER0  = 10;
    localparam int M_SER1  = 11;
    localparam int M_SER2  = 12;
    localparam int M_I2C   = 13;
    localparam int M_UART  = 14;
    localparam int NMOD    = 15;
    localparam int NSER    = 3;

    localparam logic [NMOD-1:0] GATE_RST = 15'h0000;

    // per-module gating behaviour
    typedef enum logic [1:0] {
        G_IMMED,
        G_AFTER_CPU,
        G_AFTER_BUSY,
        G_SER_RULE
    } iecg_gate_kind_t;

    typedef struct packed {
        logic            ext_clk;          // external bit clock and frame sync
        logic            serial_tx_reset_n;
        logic            serial_rx_reset_n;
        logic            busy;
        logic            dma_req;          // data request toward the dma engine
    } iecg_ser_t;

    typedef struct packed {
        logic dma_busy;
        logic instruction_cache_line_busy;
        logic instruction_cache_fetch_busy;
        logic i2c_busy;
        logic uart_busy;
    } iecg_act_t;

endpackage : iecg_pkg

// ==== core/iecg_gate_cell.sv ====
// Purpose: one module's idle handshake and clock stop
// Assumes: i_ack comes from logic on the same clock
// Notes:   the clock stops only after request and acknowledge, so no partial cycle
`timescale 1ns/1ps
module iecg_gate_cell
    import iecg_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // control
    input  wire logic i_want,
    input  wire logic i_ack,
    // status
    output logic      o_req,
    output logic      o_gated
);
    logic req_q;
    logic req_d;
    logic gated_q;
    logic gated_d;

    always_comb
    begin
        req_d   = i_want;
        gated_d = i_want & req_q & i_ack;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            req_q   <= 1'b0;
            gated_q <= 1'b0;
        end
        else
        begin
            req_q   <= req_d;
            gated_q <= gated_d;
        end
    end

    assign o_req   = req_q;
    assign o_gated = gated_q;

    a_gate_needs_req: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(gated_q) |-> $past(req_q) && $past(i_ack))
        else $error("clock gated without request and acknowledge");

endmodule : iecg_gate_cell

// ==== test/iecg_mod_model.sv ====
// Purpose: activity model of the modules that finish work before idle
// Assumes: kicked by the bench on the same edge as the idle instruction
// Notes:   busy lines hold for eight cycles, then fall on their own
`timescale 1ns/1ps
module iecg_mod_model
    import iecg_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    // control
    input  wire logic       i_kick,
    input  wire logic [5:0] i_mask,
    // activity
    output iecg_act_t       o_act,
    output logic            o_ser_busy
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    always_comb
    begin
        cnt_d = (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
        if (i_kick)
            cnt_d = 4'h0;
    end
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cnt_q <= 4'hf;
        else
            cnt_q <= cnt_d;
    end
    // work only ever starts with the idle request, never mid-idle
    assign o_act      = i_mask[4:0] & {5{cnt_q < 4'h8}};
    assign o_ser_busy = i_mask[5] & (cnt_q < 4'h8);
endmodule : iecg_mod_model

// ==== test/iecg_top_tb.sv ====
// Purpose: self-checking bench for the idle-entry sequencer
// Assumes: activity comes from iecg_mod_model
// Notes:   each test ends by waking all modules again
`timescale 1ns/1ps
module iecg_top_tb
    import iecg_pkg::*;
;
    logic              i_clk = 1'b0;
    logic              i_rstn = 1'b0;
    logic              instr = 1'b0;
    logic              kick = 1'b0;
    logic              pipe = 1'b0;
    logic [3:0]        ctrl = 4'h0;
    logic [1:0]        mic = 2'h0;
    logic [14:0]       pic = 15'h0000;
    logic [5:0]        mask = 6'h00;
    iecg_ser_t [2:0]   ser_cfg = '0;
    iecg_ser_t [2:0]   ser;
    iecg_act_t         act;
    logic              sbusy;
    logic [3:0]        stat;
    logic [14:0]       req;
    logic [14:0]       gated;
    int                num_errors = 0;
    int                checks_done = 0;
    int                cyc = 0;
    always #12.5 i_clk = ~i_clk;
    always_comb
    begin
        ser = ser_cfg;
        ser[0].busy = sbusy;
    end
    iecg_mod_model u_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_kick(kick), .i_mask(mask),
        .o_act(act), .o_ser_busy(sbusy));
    iecg_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_idle_instr(instr),
        .i_idle_control_reg(ctrl), .i_master_idle_ctrl(mic),
        .i_peripheral_idle_control_reg(pic), .i_cpu_pipe_stopped(pipe), .i_act(act),
        .i_ser(ser), .o_idle_status_reg(stat), .o_idle_req(req), .o_clk_gated(gated));
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask : step
    task automatic idle(input logic [3:0] c);
        ctrl = c;
        instr = 1'b1;
        kick = 1'b1;
        step(1);
        instr = 1'b0;
        kick = 1'b0;
    endtask : idle
    task automatic chk_vec(input logic [14:0] got, input logic [14:0] exp, input string m);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t %s got %h", $time, m, got);
        end
    endtask : chk_vec
    task automatic chk_stat(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t status got %h", $time, got);
        end
    endtask : chk_stat
    task automatic wait_gate(input int idx);
        for (int i = 0; i < 30 && gated[idx] !== 1'b1; i++)
            step(1);
    endtask : wait_gate
    task automatic wake(input string name);
        mask = 6'h00;
        idle(4'h0);
        step(4);
        chk_vec(gated, 15'h0000, "wake");
        $display("test %s done", name);
    endtask : wake
    task automatic t_peri();
        pic = 15'h63e0;
        idle(4'h2);
        step(4);
        chk_vec(gated, 15'h0000, "peri off");
        idle(4'h8);
        step(1);
        chk_stat(stat, 4'h8);
        step(3);
        chk_vec(gated, 15'h63e0, "immediate");
        wake("peri");
    endtask : t_peri
    task automatic t_busy();
        pic = 15'h6000;
        mask = 6'h03;
        idle(4'h8);
        step(4);
        chk_vec(gated, 15'h0000, "busy gated");
        chk_vec(req, 15'h6000, "busy req");
        wait_gate(13);
        step(1);
        chk_vec(gated, 15'h6000, "busy done");
        wake("busy");
    endtask : t_busy
    task automatic t_master();
        mic = 2'h3;
        mask = 6'h10;
        idle(4'h2);
        step(4);
        chk_vec(gated, 15'h0008, "host now");
        wait_gate(2);
        chk_vec(gated, 15'h000c, "dma done");
        ser_cfg[1].dma_req = 1'b1;
        step(3);
        chk_vec(gated, 15'h0008, "dma wake");
        ser_cfg[1].dma_req = 1'b0;
        wait_gate(2);
        chk_vec(gated, 15'h000c, "dma regate");
        wake("master");
        mic = 2'h0;
    endtask : t_master
    task automatic t_cpu();
        idle(4'h1);
        step(4);
        chk_vec(gated, 15'h0000, "pipe running");
        pipe = 1'b1;
        wait_gate(0);
        chk_vec(gated, 15'h0001, "cpu first");
        step(2);
        chk_vec(gated, 15'h0003, "sysctl");
        wake("cpu");
        pipe = 1'b0;
    endtask : t_cpu
    task automatic t_instruction_cache(input logic [5:0] m);
        mask = m;
        idle(4'h4);
        step(4);
        chk_vec(gated, 15'h0000, "instruction_cache busy");
        wait_gate(4);
        chk_vec(gated, 15'h0010, "instruction_cache done");
        wake("instruction_cache");
    endtask : t_instruction_cache
    task automatic t_serial();
        pic = 15'h1c00;
        mask = 6'h20;
        ser_cfg[0] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        ser_cfg[2] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        idle(4'h8);
        step(4);
        chk_vec(gated, 15'h0800, "serial busy");
        wait_gate(10);
        step(1);
        chk_vec(gated, 15'h0c00, "serial done");
        ser_cfg[0].dma_req = 1'b1;
        step(3);
        chk_vec(gated, 15'h0800, "serial wake");
        ser_cfg[0].dma_req = 1'b0;
        wait_gate(10);
        chk_vec(gated, 15'h0c00, "serial regate");
        wake("serial");
    endtask : t_serial
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            num_errors++;
            print_verdict();
        end
    end
    initial
    begin
        step(12);
        i_rstn = 1'b1;
        step(1);
        chk_vec(gated | req, 15'h0000, "reset");
        chk_stat(stat, 4'h0);
        t_peri();
        t_busy();
        t_master();
        t_cpu();
        t_instruction_cache(6'h08);
        t_instruction_cache(6'h04);
        t_serial();
        print_verdict();
    end
endmodule : iecg_top_tb
